// ---- hdl/epw_top.sv ----
// eight-channel pwm generator with eight counting digital inputs
// assumes a single 100 MHz clock, register master on the same clock,
// and asynchronous input pins that are synchronised here
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps

module epw_top
(
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic [epw_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [epw_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [epw_pkg::DATA_W-1:0]    reg_rdata,
    input  wire logic [epw_pkg::NCH-1:0]       di_pin,
    output logic      [epw_pkg::NCH-1:0]       pwm_out,
    output logic      [epw_pkg::NCH-1:0]       pwm_led,
    output logic      [epw_pkg::NCH-1:0]       di_led
);

    // ***********************************************
    // state
    // ***********************************************
    typedef struct packed {
        logic [epw_pkg::DIV_W-1:0]                      us_div;
        logic [epw_pkg::MSD_W-1:0]                      ms_div;
        logic                                           tick_us;
        logic                                           tick_ms;
        logic [epw_pkg::NCH-1:0]                        mode;
        logic [epw_pkg::NCH-1:0]                        trig;
        logic [epw_pkg::NCH-1:0]                        sync1;
        logic [epw_pkg::NCH-1:0]                        sync2;
        logic [epw_pkg::NCH-1:0]                        sync3;
        logic [epw_pkg::NCH-1:0]                        start;
        logic [epw_pkg::NCH-1:0]                        stop;
        logic [epw_pkg::NCH-1:0]                        clr;
        logic [epw_pkg::NCH-1:0][epw_pkg::TIME_W-1:0]   per;
        logic [epw_pkg::NCH-1:0][epw_pkg::TIME_W-1:0]   high;
        logic [epw_pkg::NCH-1:0][epw_pkg::TIME_W-1:0]   burst;
        logic [epw_pkg::NCH-1:0][epw_pkg::TIME_W-1:0]   ramp;
        logic [epw_pkg::NCH-1:0][epw_pkg::SCALE_W-1:0]  scale;
        logic [epw_pkg::DATA_W-1:0]                     rdata;
    } epw_top_st_t;

    epw_top_st_t q;
    epw_top_st_t d;

    logic [epw_pkg::NCH-1:0]                     rise;
    logic [epw_pkg::NCH-1:0]                     fall;
    logic [epw_pkg::NCH-1:0]                     run_v;
    logic [epw_pkg::NCH-1:0]                     pwm_v;
    logic [epw_pkg::NCH-1:0][epw_pkg::CNT_W-1:0] cnt_v;
    logic                                        ch_page;
    logic [2:0]                                  ach;
    logic [4:0]                                  sub;

    epw_ch_if chif [epw_pkg::NCH] ();

    // ***********************************************
    // decode and edge detection
    // ***********************************************

    // channel page decode
    assign ch_page = (reg_addr[9:8] == epw_pkg::CH_PAGE);
    assign ach     = reg_addr[7:5];
    assign sub     = reg_addr[4:0];

    // edges seen on the second synchroniser stage only
    assign rise = q.sync2 & ~q.sync3;
    assign fall = ~q.sync2 & q.sync3;

    // ***********************************************
    // next state
    // ***********************************************
    always_comb
    begin
        d       = q;
        d.start = '0;
        d.stop  = '0;
        d.clr   = '0;
        // microsecond and millisecond enables
        d.tick_us = 1'b0;
        d.tick_ms = 1'b0;
        if (q.us_div == 7'(epw_pkg::US_CYC - 1))
        begin
            d.us_div  = '0;
            d.tick_us = 1'b1;
            if (q.ms_div == 10'(epw_pkg::MS_US - 1))
            begin
                d.ms_div  = '0;
                d.tick_ms = 1'b1;
            end
            else
                d.ms_div = q.ms_div + 10'h001;
        end
        else
            d.us_div = q.us_div + 7'h01;
        // two-stage input synchroniser plus edge history
        d.sync1 = di_pin;
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        // hardware trigger start and stop on selected inputs
        d.start = q.trig & rise;
        d.stop  = q.trig & fall;
        // register writes
        if (reg_wr)
        begin
            if (reg_addr == epw_pkg::A_CTRL)
            begin
                // several channels may start in one cycle
                d.start = d.start | (reg_wdata[7:0] & ~q.trig);
                d.stop  = d.stop | reg_wdata[15:8];
            end
            else if (reg_addr == epw_pkg::A_MODE)
                d.mode = reg_wdata[7:0];
            else if (reg_addr == epw_pkg::A_TRIG)
                d.trig = reg_wdata[7:0];
            else if (ch_page)
            begin
                case (sub)
                    epw_pkg::S_PER:   d.per[ach]   = reg_wdata[15:0];
                    epw_pkg::S_HIGH:  d.high[ach]  = reg_wdata[15:0];
                    epw_pkg::S_BURST: d.burst[ach] = reg_wdata[15:0];
                    epw_pkg::S_SCALE: d.scale[ach] = reg_wdata[7:0];
                    epw_pkg::S_RAMP:  d.ramp[ach]  = reg_wdata[15:0];
                    epw_pkg::S_CLR:
                    begin
                        if (reg_wdata[7:0] == epw_pkg::CLR_KEY)
                            d.clr[ach] = 1'b1;
                    end
                    default: ;
                endcase
            end
        end
        // read data, one cycle after the strobe, zero when unmapped
        d.rdata = '0;
        if (reg_rd)
        begin
            if (reg_addr == epw_pkg::A_MODE)
                d.rdata = {24'h000000, q.mode};
            else if (reg_addr == epw_pkg::A_TRIG)
                d.rdata = {24'h000000, q.trig};
            else if (reg_addr == epw_pkg::A_STATUS)
                d.rdata = {16'h0000, q.sync2, run_v};
            else if (ch_page)
            begin
                case (sub)
                    epw_pkg::S_PER:   d.rdata = {16'h0000, q.per[ach]};
                    epw_pkg::S_HIGH:  d.rdata = {16'h0000, q.high[ach]};
                    epw_pkg::S_BURST: d.rdata = {16'h0000, q.burst[ach]};
                    epw_pkg::S_SCALE: d.rdata = {24'h000000, q.scale[ach]};
                    epw_pkg::S_RAMP:  d.rdata = {16'h0000, q.ramp[ach]};
                    epw_pkg::S_COUNT: d.rdata = cnt_v[ach];
                    default:          d.rdata = '0;
                endcase
            end
        end
    end

    // ***********************************************
    // state register
    // ***********************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q      <= '0;
            q.mode <= epw_pkg::MODE_RST;
            q.trig <= epw_pkg::TRIG_RST;
            for (int i = 0; i < epw_pkg::NCH; i++)
            begin
                q.per[i]   <= epw_pkg::PER_RST;
                q.high[i]  <= epw_pkg::HIGH_RST;
                q.burst[i] <= epw_pkg::BURST_RST;
                q.scale[i] <= epw_pkg::SCALE_RST;
                q.ramp[i]  <= epw_pkg::RAMP_RST;
            end
        end
        else
            q <= d;
    end

    // ***********************************************
    // channels and counters
    // ***********************************************
    for (genvar g = 0; g < epw_pkg::NCH; g++)
    begin : g_ch
        // settings out to each channel
        assign chif[g].tick_us = q.tick_us;
        assign chif[g].tick_ms = q.tick_ms;
        assign chif[g].start   = q.start[g];
        assign chif[g].stop    = q.stop[g];
        assign chif[g].mode    = q.mode[g];
        assign chif[g].period  = q.per[g];
        assign chif[g].high    = q.high[g];
        assign chif[g].burst   = q.burst[g];
        assign chif[g].scale   = q.scale[g];
        assign chif[g].ramp    = q.ramp[g];
        assign run_v[g]        = chif[g].running;
        assign pwm_v[g]        = chif[g].pwm;

        // one independent generator per output
        epw_chan u_chan
        (
            .clk (clk),
            .rst (rst),
            .ch  (chif[g])
        );

        // one event counter per input
        epw_cnt u_cnt
        (
            .clk   (clk),
            .rst   (rst),
            .inc   (rise[g]),
            .clr   (q.clr[g]),
            .count (cnt_v[g])
        );
    end

    // ***********************************************
    // outputs
    // ***********************************************
    assign reg_rdata = q.rdata;
    assign pwm_out   = pwm_v;
    assign pwm_led   = run_v;
    assign di_led    = q.sync2;

endmodule

// ---- common/epw_pkg.sv ----
// constants, register map and reset values for the eight-channel pwm block
// assumes a single 100 MHz clock and an asynchronous active-high reset
//
// Functional notes
// - eight independent channels, own period, duty, mode, run
// - 16-bit timing counts, step one to 128 us
// - 0.2 Hz to 500 kHz, phases whole microseconds
// - duty held between 0.1 and 99.9 percent; code only keeps one step high and one step low, so below 0.1 past 1000 steps
// - burst mode or continuous mode per channel
// - burst length programmable 1 through 65535
// - start by software or hardware trigger, selectable
// - hardware trigger both starts and stops output
// - 32-bit event counter per digital input
// - counters keep up with 500 kHz inputs
// - waveforms run in hardware once started
// - software starts single or several channels together
// - ramped period change, 0.1 pulse per ms
// - input is plain input or trigger source
// - output indicator lit while channel emits pulses
// - input indicator lit while input active
// - mode zero burst, one continuous, default continuous
// - writing one to clear zeroes input counter

package epw_pkg;

    // ***********************************************
    // sizes
    // ***********************************************
    localparam int NCH     = 8;
    localparam int ADDR_W  = 10;
    localparam int DATA_W  = 32;
    localparam int TIME_W  = 16;
    localparam int SCALE_W = 8;
    localparam int CNT_W   = 32;
    localparam int DIV_W   = 7;
    localparam int MSD_W   = 10;

    // ***********************************************
    // timing
    // ***********************************************
    localparam int CLK_NS   = 10;     // 100 MHz
    localparam int TICK_NS  = 1000;   // one microsecond base
    localparam int MS_US    = 1000;   // microseconds per millisecond
    localparam int US_CYC   = TICK_NS / CLK_NS;
    localparam logic [SCALE_W-1:0] SCALE_MAX = 8'h80;  // 128 us step
    localparam logic [TIME_W-1:0]  PER_MIN   = 16'h0002;

    // ***********************************************
    // register offsets
    // ***********************************************
    localparam logic [ADDR_W-1:0] A_CTRL   = 10'h000;
    localparam logic [ADDR_W-1:0] A_MODE   = 10'h004;
    localparam logic [ADDR_W-1:0] A_TRIG   = 10'h008;
    localparam logic [ADDR_W-1:0] A_STATUS = 10'h00C;
    localparam logic [1:0]        CH_PAGE  = 2'h1;   // addr[9:8]
    localparam logic [4:0]        S_PER    = 5'h00;
    localparam logic [4:0]        S_HIGH   = 5'h04;
    localparam logic [4:0]        S_BURST  = 5'h08;
    localparam logic [4:0]        S_SCALE  = 5'h0C;
    localparam logic [4:0]        S_RAMP   = 5'h10;
    localparam logic [4:0]        S_COUNT  = 5'h14;
    localparam logic [4:0]        S_CLR    = 5'h18;
    localparam logic [7:0]        CLR_KEY  = 8'h01;

    // ***********************************************
    // reset values
    // ***********************************************
    localparam logic [NCH-1:0]     MODE_RST  = 8'hFF;
    localparam logic [NCH-1:0]     TRIG_RST  = 8'h00;
    localparam logic [TIME_W-1:0]  PER_RST   = 16'h03E8;
    localparam logic [TIME_W-1:0]  HIGH_RST  = 16'h01F4;
    localparam logic [TIME_W-1:0]  BURST_RST = 16'h0001;
    localparam logic [SCALE_W-1:0] SCALE_RST = 8'h01;
    localparam logic [TIME_W-1:0]  RAMP_RST  = 16'h0000;

endpackage

// ---- common/epw_ch_if.sv ----
// settings and status passed between the top and one pwm channel
// assumes both ends run on the same clock
`timescale 1ns/1ps

interface epw_ch_if;
    logic                            tick_us;
    logic                            tick_ms;
    logic                            start;
    logic                            stop;
    logic                            mode;
    logic [epw_pkg::TIME_W-1:0]      period;
    logic [epw_pkg::TIME_W-1:0]      high;
    logic [epw_pkg::TIME_W-1:0]      burst;
    logic [epw_pkg::SCALE_W-1:0]     scale;
    logic [epw_pkg::TIME_W-1:0]      ramp;
    logic                            pwm;
    logic                            running;

    modport top  (output tick_us, tick_ms, start, stop, mode, period,
                  high, burst, scale, ramp, input pwm, running);
    modport chan (input tick_us, tick_ms, start, stop, mode, period,
                  high, burst, scale, ramp, output pwm, running);
endinterface

// ---- hdl/epw_cnt.sv ----
// 32-bit rising-edge event counter for one digital input
// assumes inc is a one-cycle pulse from synchronised logic
`timescale 1ns/1ps

module epw_cnt
(
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       inc,
    input  wire logic                       clr,
    output logic [epw_pkg::CNT_W-1:0]       count
);

    typedef struct packed {
        logic [epw_pkg::CNT_W-1:0] cnt;
    } epw_cnt_st_t;

    epw_cnt_st_t q;
    epw_cnt_st_t d;

    // count, wrap past all ones, clear keeps a same-cycle edge
    always_comb
    begin
        d = q;
        if (clr)
            d.cnt = inc ? 32'h00000001 : 32'h00000000;
        else if (inc)
            d.cnt = q.cnt + 32'h00000001;
    end

    // state register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

    assign count = q.cnt;

endmodule

// ---- hdl/epw_chan.sv ----
// one pwm channel: step prescaler, period ramp, burst counter, output
// assumes one-cycle tick pulses and start or stop pulses from the top
`timescale 1ns/1ps

module epw_chan
(
    input  wire logic  clk,
    input  wire logic  rst,
    epw_ch_if.chan     ch
);

    typedef struct packed {
        logic [epw_pkg::SCALE_W-1:0] pre;
        logic [epw_pkg::TIME_W-1:0]  pos;
        logic [epw_pkg::TIME_W-1:0]  done;
        logic [epw_pkg::TIME_W-1:0]  cur;
        logic [epw_pkg::TIME_W-1:0]  rcnt;
        logic                        run;
        logic                        out;
    } epw_chan_st_t;

    epw_chan_st_t q;
    epw_chan_st_t d;

    logic [epw_pkg::SCALE_W-1:0] scl;
    logic [epw_pkg::TIME_W-1:0]  per;
    logic [epw_pkg::TIME_W-1:0]  hi;
    logic [epw_pkg::TIME_W-1:0]  bl;

    // clamp settings into legal range
    always_comb
    begin
        scl = (ch.scale == '0) ? 8'h01 : ch.scale;
        if (scl > epw_pkg::SCALE_MAX)
            scl = epw_pkg::SCALE_MAX;
        per = (q.cur < epw_pkg::PER_MIN) ? epw_pkg::PER_MIN : q.cur;
        hi  = (ch.high == '0) ? 16'h0001 : ch.high;
        if (hi >= per)
            hi = per - 16'h0001;
        bl  = (ch.burst == '0) ? 16'h0001 : ch.burst;
    end

    // waveform generation, entirely in hardware
    always_comb
    begin
        d = q;
        // ramp current period toward target, one count per interval
        if (ch.ramp == '0)
            d.cur = ch.period;
        else if (ch.tick_ms)
        begin
            if (q.rcnt + 16'h0001 >= ch.ramp)
            begin
                d.rcnt = '0;
                if (q.cur < ch.period)
                    d.cur = q.cur + 16'h0001;
                else if (q.cur > ch.period)
                    d.cur = q.cur - 16'h0001;
            end
            else
                d.rcnt = q.rcnt + 16'h0001;
        end
        // step prescaler and period position
        if (q.run && ch.tick_us)
        begin
            if (q.pre + 8'h01 >= scl)
            begin
                d.pre = '0;
                if (q.pos + 16'h0001 >= per)
                begin
                    d.pos = '0;
                    if (!ch.mode)
                    begin
                        if (q.done + 16'h0001 >= bl)
                            d.run = 1'b0;
                        else
                            d.done = q.done + 16'h0001;
                    end
                end
                else
                    d.pos = q.pos + 16'h0001;
            end
            else
                d.pre = q.pre + 8'h01;
        end
        // start restarts, stop wins
        if (ch.start)
        begin
            d.run  = 1'b1;
            d.pos  = '0;
            d.pre  = '0;
            d.done = '0;
        end
        if (ch.stop)
            d.run = 1'b0;
        d.out = d.run && (d.pos < hi);
    end

    // state register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q     <= '0;
            q.cur <= epw_pkg::PER_RST;
        end
        else
            q <= d;
    end

    assign ch.pwm     = q.out;
    assign ch.running = q.run;

endmodule

// ---- verif/epw_monitor.sv ----
// checker for the eight-channel pwm top, sees top ports only
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps

module epw_monitor
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [9:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [7:0]  di_pin,
    input wire logic [7:0]  pwm_out,
    input wire logic [7:0]  pwm_led,
    input wire logic [7:0]  di_led
);
    logic [7:0] trig_q;
    logic       ctl_w;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // mirror of the trigger select register
    assign ctl_w = reg_wr && reg_addr == epw_pkg::A_CTRL;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            trig_q <= 8'h00;
        else if (reg_wr && reg_addr == epw_pkg::A_TRIG)
            trig_q <= reg_wdata[7:0];
    end

    // ****************************************
    // properties
    // ****************************************
    property p_sw_start;
        ctl_w && reg_wdata[15:8] == 8'h00
        |-> ##2 (~pwm_led & $past(reg_wdata[7:0] & ~trig_q, 2)) == 8'h00;
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("software start did not light channel");

    property p_sw_stop;
        ctl_w |-> ##2 (pwm_led & $past(reg_wdata[15:8], 2)) == 8'h00;
    endproperty
    a_sw_stop: assert property (p_sw_stop)
        else $error("software stop left channel running");

    property p_hw_start;
        trig_q[1] && $rose(di_led[1]) |-> ##[1:4] pwm_led[1];
    endproperty
    a_hw_start: assert property (p_hw_start)
        else $error("trigger rise did not start channel");

    property p_hw_stop;
        trig_q[1] && $fell(di_led[1]) |-> ##[1:4] !pwm_led[1];
    endproperty
    a_hw_stop: assert property (p_hw_stop)
        else $error("trigger fall did not stop channel");

    property p_hw_refuse;
        ctl_w && reg_wdata[1] && trig_q[1] && !di_led[1] && !pwm_led[1]
        |-> ##2 !pwm_led[1];
    endproperty
    a_hw_refuse: assert property (p_hw_refuse)
        else $error("software start ran a triggered channel");

    property p_di_led;
        di_led == $past(di_pin, 2);
    endproperty
    a_di_led: assert property (p_di_led)
        else $error("input indicator does not follow input");

    property p_led_out;
        (pwm_out & ~pwm_led) == 8'h00;
    endproperty
    a_led_out: assert property (p_led_out)
        else $error("output high on idle channel");

    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 32'h00000000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read cycle");

    c_start: cover property (ctl_w && reg_wdata[7:0] != 8'h00);
    c_burst_end: cover property ($fell(pwm_led[1]));
    c_hw: cover property (trig_q[1] && $rose(di_led[1]));
endmodule

bind epw_top epw_monitor u_epw_monitor (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .di_pin(di_pin),
    .pwm_out(pwm_out), .pwm_led(pwm_led), .di_led(di_led));

// ---- verif/epw_field.sv ----
// field side model: drives the digital input pins
// assumes tasks are called from the bench on the same clock
`timescale 1ns/1ps

module epw_field
(
    input wire logic  clk,
    output logic [7:0] di_pin
);
    // inputs start low
    initial di_pin = 8'h00;

    task automatic set_pin(input int ch, input logic v);
        @(posedge clk);
        di_pin[ch] <= v;
    endtask

    // n pulses, each phase half cycles long
    task automatic pulses(input int ch, input int n, input int half);
        repeat (n)
        begin
            set_pin(ch, 1'b1);
            repeat (half - 1) @(posedge clk);
            set_pin(ch, 1'b0);
            repeat (half - 1) @(posedge clk);
        end
    endtask
endmodule

// ---- verif/eight_channel_pwm_with_counters_tb.sv ----
// self-checking bench for the eight-channel pwm top
// assumes the monitor is bound and the field model drives inputs
`timescale 1ns/1ps

module eight_channel_pwm_with_counters_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [9:0]  reg_addr = 10'h000;
    logic [31:0] reg_wdata = 32'h00000000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [7:0]  di_pin, pwm_out, pwm_led, di_led;
    int          err_total = 0;
    int          checked = 0;
    int          cyc = 0;

    epw_top u_epw_top (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .di_pin(di_pin), .pwm_out(pwm_out),
        .pwm_led(pwm_led), .di_led(di_led));
    epw_field u_epw_field (.clk(clk), .di_pin(di_pin));

    // clock and run limit
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            err_total++;
            print_verdict();
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic print_verdict();
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask

    function automatic logic [9:0] ca(logic [2:0] ch, logic [4:0] s);
        return {epw_pkg::CH_PAGE, ch, s};
    endfunction

    task automatic wr(logic [9:0] a, logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(logic [9:0] a, logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk($sformatf("reg_%h", a), e, reg_rdata);
    endtask

    // length of the next phase at level v
    task automatic plen(int ch, logic v, output int n);
        n = 0;
        while (pwm_out[ch] !== v && n < 9000)
        begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (pwm_out[ch] === v && n < 9000)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic wave(int hi_e, int lo_e);
        int h, l;
        plen(0, 1'b1, h);
        plen(0, 1'b0, l);
        plen(0, 1'b1, h);
        plen(0, 1'b0, l);
        chk("high_len", hi_e, h);
        chk("low_len", lo_e, l);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rd(epw_pkg::A_MODE, 32'h000000FF);
        rd(epw_pkg::A_TRIG, 32'h00000000);
        rd(epw_pkg::A_STATUS, 32'h00000000);
        rd(ca(3'h0, epw_pkg::S_PER), 32'h000003E8);
        rd(ca(3'h0, epw_pkg::S_HIGH), 32'h000001F4);
        rd(ca(3'h7, epw_pkg::S_BURST), 32'h00000001);
        rd(ca(3'h0, epw_pkg::S_SCALE), 32'h00000001);
        rd(ca(3'h0, epw_pkg::S_COUNT), 32'h00000000);
        rd(10'h3FC, 32'h00000000);
    endtask

    task automatic t_cont();
        wr(ca(3'h0, epw_pkg::S_PER), 32'h00000004);
        wr(ca(3'h0, epw_pkg::S_HIGH), 32'h00000000);
        wr(ca(3'h2, epw_pkg::S_PER), 32'h00000004);
        wr(epw_pkg::A_CTRL, 32'h00000005);
        wave(100, 300);
        chk("led2", 32'h1, pwm_led[2]);
        wr(epw_pkg::A_CTRL, 32'h00000500);
        wr(ca(3'h0, epw_pkg::S_HIGH), 32'h00000004);
        wr(ca(3'h0, epw_pkg::S_SCALE), 32'h00000002);
        wr(epw_pkg::A_CTRL, 32'h00000001);
        wave(600, 200);
        // ramp set: new period must not jump in before the next ms step
        wr(ca(3'h0, epw_pkg::S_RAMP), 32'h00000001);
        wr(ca(3'h0, epw_pkg::S_PER), 32'h00000008);
        rd(ca(3'h0, epw_pkg::S_RAMP), 32'h00000001);
        wave(600, 200);
        wr(epw_pkg::A_CTRL, 32'h00000100);
        repeat (3) @(negedge clk);
        chk("idle_led", 32'h0, pwm_led);
        chk("idle_out", 32'h0, pwm_out);
    endtask

    task automatic t_burst();
        int n;
        logic p;
        n = 0;
        p = 1'b0;
        wr(epw_pkg::A_MODE, 32'h000000FD);
        wr(ca(3'h1, epw_pkg::S_PER), 32'h00000002);
        wr(ca(3'h1, epw_pkg::S_HIGH), 32'h00000001);
        wr(ca(3'h1, epw_pkg::S_BURST), 32'h00000003);
        wr(epw_pkg::A_CTRL, 32'h00000002);
        for (int i = 0; i < 3000 && (i < 8 || pwm_led[1] === 1'b1); i++)
        begin
            @(negedge clk);
            if (pwm_out[1] === 1'b1 && p === 1'b0)
                n++;
            p = pwm_out[1];
        end
        chk("burst_pulses", 32'd3, n);
        chk("burst_out", 32'h0, pwm_out[1]);
        rd(epw_pkg::A_STATUS, 32'h00000000);
        wr(epw_pkg::A_MODE, 32'h000000FF);
    endtask

    task automatic t_hw();
        wr(epw_pkg::A_TRIG, 32'h00000002);
        wr(epw_pkg::A_CTRL, 32'h00000002);
        repeat (5) @(negedge clk);
        chk("refused_led", 32'h0, pwm_led[1]);
        u_epw_field.set_pin(1, 1'b1);
        repeat (8) @(negedge clk);
        chk("trig_led", 32'h1, pwm_led[1]);
        chk("di_led", 32'h1, di_led[1]);
        u_epw_field.set_pin(1, 1'b0);
        repeat (8) @(negedge clk);
        chk("trig_stop", 32'h0, pwm_led[1]);
        wr(epw_pkg::A_TRIG, 32'h00000000);
    endtask

    task automatic t_count();
        u_epw_field.pulses(3, 5, 100);
        repeat (4) @(posedge clk);
        rd(ca(3'h3, epw_pkg::S_COUNT), 32'h00000005);
        rd(ca(3'h1, epw_pkg::S_COUNT), 32'h00000001);
        wr(ca(3'h3, epw_pkg::S_CLR), 32'h00000001);
        rd(ca(3'h3, epw_pkg::S_COUNT), 32'h00000000);
    endtask

    // main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_cont();
        t_burst();
        t_hw();
        t_count();
        print_verdict();
    end
endmodule
